// *** src/prr_pkg.sv ***
package prr_pkg;

    // ==========================================
    // Error report bit positions
    localparam int ERR_SOT       = 0;
    localparam int ERR_SOT_SYNC  = 1;
    localparam int ERR_EOT_SYNC  = 2;
    localparam int ERR_LP_SYNC   = 4;
    localparam int ERR_ECC_ONE   = 8;
    localparam int ERR_ECC_MULTI = 9;
    localparam int ERR_CHECKSUM  = 10;
    localparam int ERR_DT_UNK    = 11;
    localparam int ERR_VC_BAD    = 12;
    localparam int ERR_PROTO     = 15;

    // ==========================================
    // Packet constants
    localparam logic [5:0]  DT_ACK_ERR    = 6'h02;
    localparam logic [5:0]  DT_RD_SHORT   = 6'h22;
    localparam logic [5:0]  DT_RD_LONG    = 6'h1A;
    localparam logic [7:0]  ACK_TRIGGER   = 8'h84;
    localparam logic [7:0]  TE_TRIGGER    = 8'hBA;
    localparam logic [15:0] FOOTER_NONE   = 16'h0000;
    localparam logic [15:0] ERR_NONE      = 16'h0000;
    localparam logic [15:0] FATAL_MASK    = 16'h9E17;
    localparam logic [15:0] CMD_KILL_MASK = 16'h9A03;
    localparam logic [2:0]  HDR_LAST      = 3'h3;
    localparam logic [1:0]  VC_ZERO       = 2'h0;

    // ==========================================
    // Types
    typedef struct packed {
        logic        is_read;
        logic        long_rd;
        logic [1:0]  vc;
        logic [15:0] rd_data;
        logic [15:0] err;
    } prr_req_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } prr_byte_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_TRIG = 5'b00010,
        ST_RD   = 5'b00100,
        ST_ERR  = 5'b01000,
        ST_TURN = 5'b10000
    } prr_state_t;

    // Header ECC, same Hamming scheme both directions
    function automatic logic [7:0] prr_ecc(input logic [23:0] d);
        logic [7:0] e;
        e = 8'h00;
        e[0] = ^(d & 24'hF12CB7);
        e[1] = ^(d & 24'hF2555B);
        e[2] = ^(d & 24'h749A6D);
        e[3] = ^(d & 24'hB8E38E);
        e[4] = ^(d & 24'hDF03F0);
        e[5] = ^(d & 24'hEFFC00);
        return e;
    endfunction

endpackage

// *** src/prr_ctrl.sv ***
// Overview of operation
// - ECC byte computed over every reverse header
// - No checksum: footer sent as zero word
// - Turnaround after each reverse transaction
// - Tearing notice sent as single trigger byte
// - Acknowledge only when nothing stored in errors
// - Errors reported, then sticky register cleared
// - Single-bit error: use packet, flag, report
// - Multi-bit error: drop rest, flag, report
// - Report header carries correct computed ECC
// - Video mode corrects or drops, no report
// - Checksum only on long packets
// - Respond only after host turnaround
// - Clean non-read gets acknowledge trigger
// - Clean read returns requested data
// - Read with single-bit: data then report
// - Non-read single-bit: execute, then report
// - Read multi-bit: report only, no data
// - Non-read multi-bit: not executed, report
// - Fatal errors: report only, no read data; non-reads still execute on bits 2, 4, 10
// - Sync or checksum errors: report, no data
// - Bits 8,9,10,15 mark ECC, checksum, protocol
// - Report bytes: identifier, low, high, ECC
// - Acknowledge trigger pattern is 00100001
module prr_ctrl (
    input  logic              CORE_CLK,
    input  logic              RST,
    input  logic              LINK_CLK,
    input  logic              CMD_MODE,
    input  logic              ERR_EVENT,
    input  logic [15:0]       ERR_FLAGS,
    input  logic              TURN_REQ,
    input  prr_pkg::prr_req_t TURN_INFO,
    input  logic              TEAR_REQ,
    output logic              EXEC_OK,
    output logic              DROP_REST,
    output logic [15:0]       STICKY_ERR,
    output logic              TX_VALID,
    output logic [7:0]        TX_BYTE,
    output logic              TX_LAST,
    output logic              BUS_TURNAROUND,
    output logic              BUSY
);
    import prr_pkg::*;

    // ==========================================
    // Core side: sticky errors and request capture
    logic [15:0] sticky_r, sticky_nxt;
    logic        exec_r, exec_nxt, drop_r, drop_nxt;
    logic        busy_r, busy_nxt;
    logic        req_tgl_r, req_tgl_nxt;
    prr_req_t    req_r, req_nxt;
    logic        tear_tgl_r, tear_tgl_nxt;
    logic [2:0]  done_sync_r;
    logic        l_done_tgl_r, l_done_tgl_nxt;
    logic        done_ev;
    logic [15:0] turn_err;

    assign done_ev  = done_sync_r[2] ^ done_sync_r[1];
    assign turn_err = sticky_r | (ERR_EVENT ? ERR_FLAGS : ERR_NONE);

    always_comb begin
        sticky_nxt   = sticky_r;
        exec_nxt     = 1'b0;
        drop_nxt     = drop_r;
        busy_nxt     = busy_r;
        req_tgl_nxt  = req_tgl_r;
        req_nxt      = req_r;
        tear_tgl_nxt = tear_tgl_r;
        // clear after report
        // Only reported bits go; later flags wait for the next report
        if (done_ev) begin
            busy_nxt = 1'b0;
            sticky_nxt = sticky_r & ~req_r.err;
        end
        // OR accumulation, set wins over clear
        if (ERR_EVENT) begin
            sticky_nxt = (done_ev ? sticky_r & ~req_r.err : sticky_r)
                         | ERR_FLAGS;
            if (ERR_FLAGS[ERR_ECC_MULTI] || ERR_FLAGS[ERR_DT_UNK]) begin
                drop_nxt = 1'b1;
            end
        end
        if (TURN_REQ && !busy_r) begin
            req_nxt = TURN_INFO;
            req_nxt.err = CMD_MODE ? turn_err : ERR_NONE;
            exec_nxt = !TURN_INFO.is_read &&
                       ((turn_err & CMD_KILL_MASK) == ERR_NONE);
            req_tgl_nxt = ~req_tgl_r;
            busy_nxt = 1'b1;
            drop_nxt = 1'b0;
            if (!CMD_MODE) begin
                sticky_nxt = ERR_NONE;
            end
        end
        if (TEAR_REQ && !busy_r && !TURN_REQ) begin
            tear_tgl_nxt = ~tear_tgl_r;
            busy_nxt = 1'b1;
            // Trigger reports nothing, so its end clears nothing
            req_nxt.err = ERR_NONE;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sticky_r    <= ERR_NONE;
            exec_r      <= 1'b0;
            drop_r      <= 1'b0;
            busy_r      <= 1'b0;
            req_tgl_r   <= 1'b0;
            req_r       <= '0;
            tear_tgl_r  <= 1'b0;
            done_sync_r <= 3'h0;
        end else begin
            sticky_r    <= sticky_nxt;
            exec_r      <= exec_nxt;
            drop_r      <= drop_nxt;
            busy_r      <= busy_nxt;
            req_tgl_r   <= req_tgl_nxt;
            req_r       <= req_nxt;
            tear_tgl_r  <= tear_tgl_nxt;
            done_sync_r <= {done_sync_r[1:0], l_done_tgl_r};
        end
    end

    assign EXEC_OK    = exec_r;
    assign DROP_REST  = drop_r;
    assign STICKY_ERR = sticky_r;
    assign BUSY       = busy_r;

    // ==========================================
    // Link side
    // Request word held stable while busy, so toggle sync suffices
    logic [2:0]  l_req_sync_r, l_tear_sync_r;
    prr_state_t  l_st_r, l_st_nxt;
    prr_req_t    l_req_r, l_req_nxt;
    logic [2:0]  l_idx_r, l_idx_nxt;
    logic [15:0] l_cnt_r, l_cnt_nxt;
    logic        l_vld_r, l_vld_nxt, l_last_r, l_last_nxt;
    logic [7:0]  l_byte_r, l_byte_nxt;
    logic        l_bta_r, l_bta_nxt;
    logic        l_req_ev, l_tear_ev, l_fatal;
    logic [23:0] rd_hdr, er_hdr;
    logic [7:0]  rd_ecc, er_ecc;
    // Core request word, static while busy
    prr_req_t    req_held;

    assign req_held  = req_r;
    assign l_req_ev  = l_req_sync_r[2] ^ l_req_sync_r[1];
    assign l_tear_ev = l_tear_sync_r[2] ^ l_tear_sync_r[1];
    // sync and checksum also suppress data
    assign l_fatal   = (l_req_r.err & FATAL_MASK) != ERR_NONE;
    assign rd_hdr = {l_req_r.rd_data,
                     l_req_r.vc, l_req_r.long_rd ? DT_RD_LONG : DT_RD_SHORT};
    assign rd_ecc = prr_ecc(rd_hdr);
    assign er_hdr = {l_req_r.err, l_req_r.vc, DT_ACK_ERR};
    assign er_ecc = prr_ecc(er_hdr);

    always_comb begin
        l_st_nxt       = l_st_r;
        l_req_nxt      = l_req_r;
        l_idx_nxt      = l_idx_r;
        l_cnt_nxt      = l_cnt_r;
        l_vld_nxt      = 1'b0;
        l_last_nxt     = 1'b0;
        l_byte_nxt     = l_byte_r;
        l_bta_nxt      = 1'b0;
        l_done_tgl_nxt = l_done_tgl_r;
        unique case (l_st_r)
            ST_IDLE: begin
                if (l_req_ev) begin
                    l_req_nxt = req_held;
                    l_idx_nxt = 3'h0;
                    l_cnt_nxt = 16'h0000;
                    if (req_held.err != ERR_NONE) begin
                        if (req_held.is_read &&
                            (req_held.err & FATAL_MASK) == ERR_NONE) begin
                            l_st_nxt = ST_RD;
                        end else begin
                            l_st_nxt = ST_ERR;
                        end
                    end else if (req_held.is_read) begin
                        l_st_nxt = ST_RD;
                    end else begin
                        // ack only with no stored errors
                        l_st_nxt = ST_TRIG;
                        l_byte_nxt = ACK_TRIGGER;
                    end
                end else if (l_tear_ev) begin
                    l_st_nxt = ST_TRIG;
                    l_byte_nxt = TE_TRIGGER;
                end
            end
            ST_TRIG: begin
                // trigger byte, bit 0 first on the wire
                l_vld_nxt  = 1'b1;
                l_last_nxt = 1'b1;
                l_st_nxt   = ST_TURN;
            end
            ST_RD: begin
                l_vld_nxt = 1'b1;
                l_idx_nxt = l_idx_r + 3'h1;
                unique case (l_idx_r)
                    3'h0: l_byte_nxt = rd_hdr[7:0];
                    3'h1: l_byte_nxt = rd_hdr[15:8];
                    3'h2: l_byte_nxt = rd_hdr[23:16];
                    3'h3: l_byte_nxt = rd_ecc;
                    3'h4: begin
                        // Payload is a repeated data byte pattern
                        l_byte_nxt = l_cnt_r[0] ? l_req_r.rd_data[15:8]
                                                : l_req_r.rd_data[7:0];
                        l_cnt_nxt = l_cnt_r + 16'h0001;
                        if (l_cnt_nxt != l_req_r.rd_data) begin
                            l_idx_nxt = 3'h4;
                        end
                    end
                    // zero footer in place of checksum
                    3'h5: l_byte_nxt = FOOTER_NONE[7:0];
                    default: l_byte_nxt = FOOTER_NONE[15:8];
                endcase
                if ((!l_req_r.long_rd && l_idx_r == HDR_LAST) ||
                    (l_req_r.long_rd && l_idx_r == 3'h6) ||
                    (l_req_r.long_rd && l_req_r.rd_data == 16'h0000 &&
                     l_idx_r == 3'h3)) begin
                    l_idx_nxt = l_req_r.long_rd && l_idx_r == 3'h3
                                ? 3'h5 : 3'h0;
                    if (l_idx_nxt == 3'h0) begin
                        l_st_nxt = (l_req_r.err != ERR_NONE) ? ST_ERR
                                                             : ST_TURN;
                        l_last_nxt = (l_req_r.err == ERR_NONE);
                    end
                end
            end
            ST_ERR: begin
                l_vld_nxt = 1'b1;
                l_idx_nxt = l_idx_r + 3'h1;
                unique case (l_idx_r)
                    3'h0:    l_byte_nxt = er_hdr[7:0];
                    3'h1:    l_byte_nxt = er_hdr[15:8];
                    3'h2:    l_byte_nxt = er_hdr[23:16];
                    default: l_byte_nxt = er_ecc;
                endcase
                if (l_idx_r == HDR_LAST) begin
                    l_last_nxt = 1'b1;
                    l_st_nxt   = ST_TURN;
                end
            end
            ST_TURN: begin
                l_bta_nxt      = 1'b1;
                l_done_tgl_nxt = ~l_done_tgl_r;
                l_st_nxt       = ST_IDLE;
            end
            default: l_st_nxt = ST_IDLE;
        endcase
        if (l_fatal && l_st_r == ST_RD) begin
            l_st_nxt = ST_ERR;
        end
    end

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            l_req_sync_r  <= 3'h0;
            l_tear_sync_r <= 3'h0;
            l_done_tgl_r  <= 1'b0;
            l_st_r        <= ST_IDLE;
            l_req_r       <= '0;
            l_idx_r       <= 3'h0;
            l_cnt_r       <= 16'h0000;
            l_vld_r       <= 1'b0;
            l_last_r      <= 1'b0;
            l_byte_r      <= 8'h00;
            l_bta_r       <= 1'b0;
        end else begin
            l_req_sync_r  <= {l_req_sync_r[1:0], req_tgl_r};
            l_tear_sync_r <= {l_tear_sync_r[1:0], tear_tgl_r};
            l_done_tgl_r  <= l_done_tgl_nxt;
            l_st_r        <= l_st_nxt;
            l_req_r       <= l_req_nxt;
            l_idx_r       <= l_idx_nxt;
            l_cnt_r       <= l_cnt_nxt;
            l_vld_r       <= l_vld_nxt;
            l_last_r      <= l_last_nxt;
            l_byte_r      <= l_byte_nxt;
            l_bta_r       <= l_bta_nxt;
        end
    end

    assign TX_VALID       = l_vld_r;
    assign TX_BYTE        = l_byte_r;
    assign TX_LAST        = l_last_r;
    assign BUS_TURNAROUND = l_bta_r;

    // ==========================================
    // Checks
    // cleared after report done
    a_sticky_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
        (done_ev && !ERR_EVENT)
        |=> ((sticky_r & $past(req_r.err)) == ERR_NONE))
        else $error("sticky errors not cleared after report");
    a_sticky_or: assert property (@(posedge CORE_CLK) disable iff (RST)
        ERR_EVENT |=> ((sticky_r & $past(ERR_FLAGS)) == $past(ERR_FLAGS)))
        else $error("error flag lost");
    a_turn_after: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_vld_r && l_last_r) |-> ##[1:2] l_bta_r)
        else $error("no turnaround after response");
    a_no_exec: assert property (@(posedge CORE_CLK) disable iff (RST)
        (TURN_REQ && !busy_r && turn_err[ERR_ECC_MULTI]) |=> !exec_r)
        else $error("command executed despite multi-bit error");
    a_ack_clean: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_st_r == ST_TRIG && l_byte_r == ACK_TRIGGER)
        |-> (l_req_r.err == ERR_NONE))
        else $error("acknowledge sent with errors stored");
    // no read data after fatal error
    a_no_data: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_st_r == ST_RD) |-> !l_fatal)
        else $error("read data with fatal error");
    a_quiet_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
        !busy_r |-> ##1 (!busy_r || $past(TURN_REQ) || $past(TEAR_REQ)))
        else $error("activity without a request");
    a_rep_ecc: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_st_r == ST_ERR && l_idx_r == HDR_LAST)
        |=> (l_byte_r == er_ecc && l_last_r))
        else $error("report ECC byte wrong");
    sequence s_rep_head;
        (l_vld_r && l_byte_r == er_hdr[7:0]) ##1
        (l_vld_r && l_byte_r == er_hdr[15:8]) ##1
        (l_vld_r && l_byte_r == er_hdr[23:16]);
    endsequence
    sequence s_rep_tail;
        (l_vld_r && l_last_r && l_byte_r == er_ecc) ##1 l_bta_r;
    endsequence
    a_rep_order: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_st_r == ST_ERR && l_idx_r == 3'h0)
        |=> s_rep_head ##1 s_rep_tail)
        else $error("report bytes out of order");
    a_drop_multi: assert property (@(posedge CORE_CLK) disable iff (RST)
        (ERR_EVENT && ERR_FLAGS[ERR_ECC_MULTI] && !TURN_REQ)
        |=> drop_r)
        else $error("rest of transmission not dropped");
    a_exec_single: assert property (@(posedge CORE_CLK) disable iff (RST)
        (TURN_REQ && !busy_r && !TURN_INFO.is_read &&
         (turn_err == ERR_NONE ||
          (turn_err[ERR_ECC_ONE] && $onehot(turn_err))))
        |=> exec_r)
        else $error("clean or corrected command not executed");
    a_tear_byte: assert property (@(posedge LINK_CLK) disable iff (RST)
        (l_st_r == ST_IDLE && l_tear_ev && !l_req_ev)
        |=> (l_st_r == ST_TRIG && l_byte_r == TE_TRIGGER)
        ##1 (l_vld_r && l_last_r && l_byte_r == TE_TRIGGER))
        else $error("tearing trigger byte wrong");

endmodule // prr_ctrl

// *** verification/prr_host_model.sv ***
// ==========================================
// Host side receiver of the reverse link
module prr_host_model (
    input wire logic       LINK_CLK,
    input wire logic       RST,
    input wire logic       ECC_EN,
    input wire logic       TX_VALID,
    input wire logic [7:0] TX_BYTE,
    input wire logic       TX_LAST,
    input wire logic       BUS_TURNAROUND
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got[$];
    logic [7:0] frm[$];
    int         frames = 0;
    int         bad    = 0;
    logic       last_d = 1'b0;

    // Own copy of the header code, kept apart from the device side
    function automatic logic [7:0] ecc8(input logic [23:0] d);
        ecc8    = 8'h00;
        ecc8[0] = ^(d & 24'hF12CB7);
        ecc8[1] = ^(d & 24'hF2555B);
        ecc8[2] = ^(d & 24'h749A6D);
        ecc8[3] = ^(d & 24'hB8E38E);
        ecc8[4] = ^(d & 24'hDF03F0);
        ecc8[5] = ^(d & 24'hEFFC00);
    endfunction

    // ==========================================
    // Byte capture, one frame per turnaround
    always @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            frm.delete();
            last_d <= 1'b0;
        end else begin
            // link handed back after last byte
            if (last_d && BUS_TURNAROUND !== 1'b1) bad++;
            last_d <= (TX_VALID === 1'b1) && (TX_LAST === 1'b1);
            if (TX_VALID === 1'b1) frm.push_back(TX_BYTE);
            if (BUS_TURNAROUND === 1'b1) begin
                // header code checked only when enabled
                if (ECC_EN && frm.size() >= 4 &&
                    ecc8({frm[2], frm[1], frm[0]}) !== frm[3]) bad++;
                foreach (frm[i]) got.push_back(frm[i]);
                frm.delete();
                frames++;
            end
        end
    end
endmodule // prr_host_model

// *** verification/tb_top.sv ***
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
    import prr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        CORE_CLK = 1'b0;
    logic        LINK_CLK = 1'b0;
    logic        RST      = 1'b1;
    logic        CMD_MODE = 1'b1;
    logic        ERR_EVENT = 1'b0;
    logic [15:0] ERR_FLAGS = 16'h0000;
    logic        TURN_REQ = 1'b0;
    prr_req_t    TURN_INFO = '0;
    logic        TEAR_REQ = 1'b0;
    logic        EXEC_OK, DROP_REST, TX_VALID, TX_LAST, BUS_TURNAROUND, BUSY;
    logic [15:0] STICKY_ERR;
    logic [7:0]  TX_BYTE;
    int          err_count  = 0;
    int          num_checks = 0;
    int          seed       = 32'h59A8;
    logic [15:0] sticky_m   = 16'h0000;
    bit          exec_seen;
    logic [15:0] errs[11] = '{16'h0000, 16'h0100, 16'h0200, 16'h0400,
        16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0800, 16'h1000,
        16'h8000};

    always #5 CORE_CLK = ~CORE_CLK;
    // Offset start keeps the two clocks out of step
    initial begin
        #2.3;
        forever #7.5 LINK_CLK = ~LINK_CLK;
    end

    prr_ctrl u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .LINK_CLK(LINK_CLK),
        .CMD_MODE(CMD_MODE), .ERR_EVENT(ERR_EVENT), .ERR_FLAGS(ERR_FLAGS),
        .TURN_REQ(TURN_REQ), .TURN_INFO(TURN_INFO), .TEAR_REQ(TEAR_REQ),
        .EXEC_OK(EXEC_OK), .DROP_REST(DROP_REST), .STICKY_ERR(STICKY_ERR),
        .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST),
        .BUS_TURNAROUND(BUS_TURNAROUND), .BUSY(BUSY));

    prr_host_model u_host (.LINK_CLK(LINK_CLK), .RST(RST), .ECC_EN(1'b1),
        .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_LAST(TX_LAST),
        .BUS_TURNAROUND(BUS_TURNAROUND));

    always @(posedge CORE_CLK) if (EXEC_OK === 1'b1) exec_seen = 1'b1;

    task automatic tick;
        @(posedge CORE_CLK);
        #1;
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int j = 0; j < 8; j++) rev8[j] = b[7 - j];
    endfunction

    function automatic void hdr(ref logic [7:0] q[$], input logic [7:0] di,
                                input logic [15:0] w);
        q.push_back(di);
        q.push_back(w[7:0]);
        q.push_back(w[15:8]);
        q.push_back(u_host.ecc8({w, di}));
    endfunction

    task automatic ev_pulse(input logic [15:0] f);
        ERR_EVENT = 1'b1;
        ERR_FLAGS = f;
        tick;
        ERR_EVENT = 1'b0;
        sticky_m  = sticky_m | f;
    endtask

    // ==========================================
    // Wait for one frame and compare it byte by byte
    task automatic collect(ref logic [7:0] q[$], input int n0);
        int         k;
        logic [7:0] b;
        for (k = 0; k < 500 && u_host.frames == n0; k++) tick;
        for (k = 0; k < 50 && BUSY !== 1'b0; k++) tick;
        repeat (4) tick;
        `CHK(u_host.frames - n0, 1)
        `CHK(u_host.got.size(), q.size())
        for (k = 0; k < q.size() && u_host.got.size() > 0; k++) begin
            b = u_host.got.pop_front();
            `CHK(b, q[k])
        end
        u_host.got.delete();
    endtask

    task automatic respond(input bit rd, input bit lng, input logic [1:0] vc,
                           input logic [15:0] dat, input logic [15:0] ev,
                           input bit dup);
        int          n0, k;
        logic [15:0] e;
        logic [7:0]  q[$];
        n0 = u_host.frames;
        e  = sticky_m | ev;
        exec_seen = 1'b0;
        // clean read, or single-bit only, returns data
        if (rd && (e == 16'h0000 || e == 16'h0100)) begin
            hdr(q, {vc, lng ? DT_RD_LONG : DT_RD_SHORT}, dat);
            if (lng) begin
                for (k = 0; k < dat; k++)
                    q.push_back(k[0] ? dat[15:8] : dat[7:0]);
                q.push_back(8'h00);
                q.push_back(8'h00);
            end
        end
        // acknowledge pattern sent first bit first
        if (!rd && e == 16'h0000) q.push_back(rev8(8'h21));
        // any stored error gives the report
        if (e != 16'h0000) hdr(q, {vc, DT_ACK_ERR}, e);
        TURN_REQ  = 1'b1;
        TURN_INFO = '{rd, lng, vc, dat, 16'h0000};
        ERR_EVENT = (ev != 16'h0000);
        ERR_FLAGS = ev;
        tick;
        ERR_EVENT = 1'b0;
        if (dup) tick;
        TURN_REQ  = 1'b0;
        collect(q, n0);
        sticky_m = 16'h0000;
        `CHK(STICKY_ERR, 16'h0000)
        if (!rd && (e == 16'h0000 || e == 16'h0100))
            `CHK(exec_seen, 1'b1)
        else if (!rd && (e & 16'h9A03) != 16'h0000)
            `CHK(exec_seen, 1'b0)
    endtask

    task automatic tally_and_finish;
        err_count += u_host.bad;
        $display("Checks made: %0d, mismatches: %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================
    // Watchdog, well past the expected run length
    initial begin
        #500000;
        err_count++;
        tally_and_finish;
    end

    initial begin
        logic [7:0]  q[$];
        logic [15:0] d;
        bit          r, l;
        repeat (5) @(posedge CORE_CLK);
        #1;
        RST = 1'b0;
        tick;
        // Accumulate without turnaround: nothing may go out
        ev_pulse(16'h0400);
        tick;
        ev_pulse(16'h0200);
        tick;
        `CHK(STICKY_ERR, 16'h0600)
        `CHK(DROP_REST, 1'b1)
        repeat (30) tick;
        `CHK(u_host.frames, 0)
        respond(1'b0, 1'b0, 2'h1, 16'h1234, 16'h0000, 1'b0);
        `CHK(DROP_REST, 1'b0)
        // Tearing notice is a lone trigger byte
        // A pending error must outlive the trigger
        ev_pulse(16'h0010);
        q.push_back(TE_TRIGGER);
        TEAR_REQ = 1'b1;
        tick;
        TEAR_REQ = 1'b0;
        collect(q, u_host.frames);
        `CHK(STICKY_ERR, 16'h0010)
        // Every error code, random reads and writes, one refused repeat
        for (int i = 0; i < 22; i++) begin
            r = $random(seed);
            l = $random(seed);
            d = $random(seed);
            if (l) d = d & 16'h0007;
            respond(r, l, 2'($random(seed)), d, errs[i % 11], i == 3);
        end
        // Video mode still drops the rest after a multi-bit error
        CMD_MODE = 1'b0;
        ev_pulse(16'h0200);
        tick;
        `CHK(DROP_REST, 1'b1)
        tally_and_finish;
    end
endmodule // tb_top
